// ===== verilog/abr_defs.vh
// Purpose: Shared constants of the acquisition buffer readout block.
// Assumes: Included by its bare name from the design file and the bench.
// Notes: Byte offsets on the AXI4-Lite register bus, field positions, codes.
`ifndef ABR_DEFS_VH
`define ABR_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ABR_OFF_CTRL 8'h00
`define ABR_OFF_TERM 8'h04
`define ABR_OFF_CMD 8'h08
`define ABR_OFF_STAT 8'h0c
`define ABR_OFF_QRY 8'h10
`define ABR_OFF_LVL 8'h14
`define ABR_OFF_ISTAT 8'h18
`define ABR_OFF_IMASK 8'h1c

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define ABR_CTRL_ACQ 0
`define ABR_CTRL_BURST 1
`define ABR_CTRL_BIN 2
`define ABR_CTRL_SEP 3
`define ABR_CTRL_W 4
`define ABR_CTRL_RST 4'h0
`define ABR_TERM_SCAN 3:0
`define ABR_TERM_BLK 7:4
`define ABR_TERM_RST 8'h00
`define ABR_TCODE_NONE 4'h0
`define ABR_ST_AVAIL 0
`define ABR_ST_BUSY 1
`define ABR_ST_FULL 2
`define ABR_IRQ_SCAN 0
`define ABR_IRQ_CONF 1
`define ABR_IRQ_DONE 2
`define ABR_IRQ_W 3
`define ABR_IRQ_RST 3'h0

// ----------------------------------------------------------------
// Request types, output tags, bus answers, burst unit
// ----------------------------------------------------------------
`define ABR_TYPE_QUERY 2'h0
`define ABR_TYPE_ONE 2'h1
`define ABR_TYPE_BLOCK 2'h2
`define ABR_TYPE_ALL 2'h3
`define ABR_TAG_READ 2'h0
`define ABR_TAG_SEP 2'h1
`define ABR_TAG_SCAN 2'h2
`define ABR_TAG_BLK 2'h3
`define ABR_RESP_OKAY 2'h0
`define ABR_RESP_SLVERR 2'h2
`define ABR_BURST_SAMPLES 256

`endif

// ===== verilog/abr_readout.v
// Purpose: Acquisition buffer readout: FIFO of scans, buffered-read engine, status.
// Assumes: Acquisition stream and output queue share aclk; AXI4-Lite registers.
// Notes: Output tokens carry a tag; terminator tokens carry the terminator code.
`timescale 1ns/1ps
`include "abr_defs.vh"
`default_nettype none

module abr_readout #(
	parameter AW = 8,
	parameter DEPTH_LOG2 = 6,
	parameter BURST_N = `ABR_BURST_SAMPLES
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite register slave
	input wire [AW-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [AW-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Acquisition stream
	input wire acq_valid,
	output wire acq_ready,
	input wire [31:0] acq_data,
	input wire acq_scan_end,
	input wire acq_block_end,
	// Output queue
	output reg out_valid,
	input wire out_ready,
	output reg [31:0] out_data,
	output reg [1:0] out_tag,
	// Status
	output wire scan_avail,
	output wire irq
);

	localparam DEPTH = 1 << DEPTH_LOG2;
	localparam CW = DEPTH_LOG2 + 1;
	localparam SW = (BURST_N > 1) ? $clog2(BURST_N) : 1;
	localparam integer SMP_LAST_I = BURST_N - 1;
	localparam [SW-1:0] SMP_LAST = SMP_LAST_I[SW-1:0];
	localparam [CW-1:0] ONE_C = {{(CW-1){1'b0}}, 1'b1};
	localparam [3:0] S_IDLE = 4'h1;
	localparam [3:0] S_RD = 4'h2;
	localparam [3:0] S_SEP = 4'h4;
	localparam [3:0] S_TRM = 4'h8;

	// ----------------------------------------------------------------
	// Byte-lane merge for register writes
	// ----------------------------------------------------------------
	function [31:0] wmerge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer i;
		begin
			wmerge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					wmerge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction

	reg [`ABR_CTRL_W-1:0] ctrl_ff;
	reg [7:0] term_ff;
	reg [`ABR_IRQ_W-1:0] istat_ff;
	reg [`ABR_IRQ_W-1:0] imask_ff;
	reg [CW-1:0] q_scans_ff;
	reg [CW-1:0] q_blks_ff;
	reg [CW-1:0] wr_ptr_ff;
	reg [CW-1:0] rd_ptr_ff;
	reg [CW-1:0] scan_cnt_ff;
	reg [CW-1:0] blk_cnt_ff;
	reg [SW-1:0] smp_ff;
	reg [33:0] mem [0:DEPTH-1];
	reg [3:0] st_ff;
	reg [1:0] mode_ff;
	reg [CW-1:0] left_ff;
	reg last_ff;
	reg blkt_ff;
	reg [3:0] tcode_ff;
	reg aw_got_ff;
	reg w_got_ff;
	reg [AW-1:0] aw_addr_ff;
	reg [31:0] w_data_ff;
	reg [3:0] w_strb_ff;

	// ----------------------------------------------------------------
	// Buffer write side: acquisition scans in FIFO order
	// ----------------------------------------------------------------
	wire full = (wr_ptr_ff[CW-1] != rd_ptr_ff[CW-1]) &&
		(wr_ptr_ff[CW-2:0] == rd_ptr_ff[CW-2:0]);
	wire burst = ctrl_ff[`ABR_CTRL_BURST];
	wire binary = ctrl_ff[`ABR_CTRL_BIN];
	assign acq_ready = ctrl_ff[`ABR_CTRL_ACQ] && !full;
	wire push = acq_valid && acq_ready;
	// Burst mode ignores the scan strobe and ends a scan every BURST_N samples
	wire in_eos = burst ? (smp_ff == SMP_LAST) : acq_scan_end;
	wire in_eob = in_eos && acq_block_end;
	wire [33:0] head = mem[rd_ptr_ff[CW-2:0]];
	wire head_eos = head[32];
	wire head_eob = head[33];

	// Storage array has no reset; only pointers define content
	always @(posedge aclk) begin
		if (push)
			mem[wr_ptr_ff[CW-2:0]] <= {in_eob, in_eos, acq_data};
	end

	// ----------------------------------------------------------------
	// Readout engine (combinational next state)
	// ----------------------------------------------------------------
	wire slot_free = !out_valid || out_ready;
	wire busy = (st_ff != S_IDLE) || out_valid;
	wire wr_fire = aw_got_ff && w_got_ff && !s_axi_bvalid;
	wire cmd_go = wr_fire && (aw_addr_ff[7:0] == `ABR_OFF_CMD) && w_strb_ff[0];
	wire [1:0] cmd_type = w_data_ff[1:0];
	wire xfer_end = (mode_ff == `ABR_TYPE_ONE) ? 1'b1 :
		(mode_ff == `ABR_TYPE_BLOCK) ? head_eob : (left_ff == ONE_C);
	wire use_blk = head_eob && (mode_ff != `ABR_TYPE_ONE);
	wire [3:0] tcode = use_blk ? term_ff[`ABR_TERM_BLK] : term_ff[`ABR_TERM_SCAN];
	wire tok_term = !binary && (tcode != `ABR_TCODE_NONE);
	wire sep_on = ctrl_ff[`ABR_CTRL_SEP] && !binary;
	reg [3:0] nxt_st;
	reg nxt_pop;
	reg nxt_emit;
	reg [1:0] nxt_tag;
	reg [31:0] nxt_data;
	reg ev_conf;
	reg ev_done;
	reg qry_go;
	reg start;

	always @* begin
		nxt_st = st_ff;
		nxt_pop = 1'b0;
		nxt_emit = 1'b0;
		nxt_tag = `ABR_TAG_READ;
		nxt_data = head[31:0];
		ev_conf = 1'b0;
		ev_done = 1'b0;
		qry_go = 1'b0;
		start = 1'b0;
		if (cmd_go) begin
			if (cmd_type == `ABR_TYPE_QUERY) begin
				qry_go = 1'b1;
				ev_done = 1'b1;
			end else if (busy) begin
				ev_conf = 1'b1;
			end else if ((cmd_type == `ABR_TYPE_BLOCK) ? (blk_cnt_ff == {CW{1'b0}}) :
				(scan_cnt_ff == {CW{1'b0}})) begin
				ev_conf = 1'b1;
			end else begin
				start = 1'b1;
				nxt_st = S_RD;
			end
		end
		case (st_ff)
			S_IDLE: begin
			end
			S_RD: begin
				if (slot_free) begin
					nxt_pop = 1'b1;
					nxt_emit = 1'b1;
					if (!head_eos)
						nxt_st = sep_on ? S_SEP : S_RD;
					else if (tok_term)
						nxt_st = S_TRM;
					else begin
						nxt_st = xfer_end ? S_IDLE : S_RD;
						ev_done = xfer_end;
					end
				end
			end
			S_SEP: begin
				if (slot_free) begin
					nxt_emit = 1'b1;
					nxt_tag = `ABR_TAG_SEP;
					nxt_data = 32'h0000_0000;
					nxt_st = S_RD;
				end
			end
			S_TRM: begin
				if (slot_free) begin
					nxt_emit = 1'b1;
					nxt_tag = blkt_ff ? `ABR_TAG_BLK : `ABR_TAG_SCAN;
					nxt_data = {28'h000_0000, tcode_ff};
					nxt_st = last_ff ? S_IDLE : S_RD;
					ev_done = last_ff;
				end
			end
			default: nxt_st = S_IDLE;
		endcase
	end

	wire pop = nxt_pop;
	wire ev_scan = push && in_eos;

	// ----------------------------------------------------------------
	// Engine, pointers, counters and output queue registers
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= S_IDLE;
			mode_ff <= `ABR_TYPE_QUERY;
			left_ff <= {CW{1'b0}};
			last_ff <= 1'b0;
			blkt_ff <= 1'b0;
			tcode_ff <= `ABR_TCODE_NONE;
			wr_ptr_ff <= {CW{1'b0}};
			rd_ptr_ff <= {CW{1'b0}};
			scan_cnt_ff <= {CW{1'b0}};
			blk_cnt_ff <= {CW{1'b0}};
			smp_ff <= {SW{1'b0}};
			q_scans_ff <= {CW{1'b0}};
			q_blks_ff <= {CW{1'b0}};
			out_valid <= 1'b0;
			out_data <= 32'h0000_0000;
			out_tag <= `ABR_TAG_READ;
		end else begin
			st_ff <= nxt_st;
			if (start) begin
				mode_ff <= cmd_type;
				left_ff <= scan_cnt_ff;
			end
			if (pop && head_eos) begin
				left_ff <= left_ff - ONE_C;
				last_ff <= xfer_end;
				blkt_ff <= use_blk;
				tcode_ff <= tcode;
			end
			if (push) begin
				wr_ptr_ff <= wr_ptr_ff + ONE_C;
				smp_ff <= (!burst || in_eos) ? {SW{1'b0}} : smp_ff + 1'b1;
			end
			if (pop)
				rd_ptr_ff <= rd_ptr_ff + ONE_C;
			// Complete scans and blocks held; partial scans are not readable
			if (ev_scan && !(pop && head_eos))
				scan_cnt_ff <= scan_cnt_ff + ONE_C;
			else if (!ev_scan && pop && head_eos)
				scan_cnt_ff <= scan_cnt_ff - ONE_C;
			if ((push && in_eob) && !(pop && head_eob))
				blk_cnt_ff <= blk_cnt_ff + ONE_C;
			else if (!(push && in_eob) && pop && head_eob)
				blk_cnt_ff <= blk_cnt_ff - ONE_C;
			if (qry_go) begin
				q_scans_ff <= scan_cnt_ff;
				q_blks_ff <= blk_cnt_ff;
			end
			if (nxt_emit) begin
				out_valid <= 1'b1;
				out_data <= nxt_data;
				out_tag <= nxt_tag;
			end else if (out_ready)
				out_valid <= 1'b0;
		end
	end

	assign scan_avail = (scan_cnt_ff != {CW{1'b0}});

	// ----------------------------------------------------------------
	// AXI4-Lite write channel and control registers
	// ----------------------------------------------------------------
	wire [7:0] wa = aw_addr_ff[7:0];
	wire wa_ok = (wa == `ABR_OFF_CTRL) || (wa == `ABR_OFF_TERM) || (wa == `ABR_OFF_CMD) ||
		(wa == `ABR_OFF_ISTAT) || (wa == `ABR_OFF_IMASK);
	wire [31:0] wm_ctrl = wmerge({28'h000_0000, ctrl_ff}, w_data_ff, w_strb_ff);
	wire [31:0] wm_term = wmerge({24'h00_0000, term_ff}, w_data_ff, w_strb_ff);
	wire [31:0] wm_mask = wmerge({29'h0000_0000, imask_ff}, w_data_ff, w_strb_ff);
	wire [`ABR_IRQ_W-1:0] iclr = (wr_fire && wa == `ABR_OFF_ISTAT && w_strb_ff[0]) ?
		w_data_ff[`ABR_IRQ_W-1:0] : {`ABR_IRQ_W{1'b0}};
	wire [`ABR_IRQ_W-1:0] iev;
	assign iev[`ABR_IRQ_SCAN] = ev_scan;
	assign iev[`ABR_IRQ_CONF] = ev_conf;
	assign iev[`ABR_IRQ_DONE] = ev_done;
	assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
	assign s_axi_wready = !w_got_ff && !s_axi_bvalid;

	// Address and data are caught independently, in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			aw_addr_ff <= {AW{1'b0}};
			w_data_ff <= 32'h0000_0000;
			w_strb_ff <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ABR_RESP_OKAY;
			ctrl_ff <= `ABR_CTRL_RST;
			term_ff <= `ABR_TERM_RST;
			imask_ff <= `ABR_IRQ_RST;
			istat_ff <= `ABR_IRQ_RST;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wa_ok ? `ABR_RESP_OKAY : `ABR_RESP_SLVERR;
				if (wa == `ABR_OFF_CTRL)
					ctrl_ff <= wm_ctrl[`ABR_CTRL_W-1:0];
				if (wa == `ABR_OFF_TERM)
					term_ff <= wm_term[7:0];
				if (wa == `ABR_OFF_IMASK)
					imask_ff <= wm_mask[`ABR_IRQ_W-1:0];
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			// New event wins over a write-one clear in the same cycle
			istat_ff <= (istat_ff & ~iclr) | iev;
		end
	end

	assign irq = |(istat_ff & imask_ff);

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	assign s_axi_arready = !s_axi_rvalid;
	reg [31:0] rd_mux;
	reg rd_ok;

	always @* begin
		rd_mux = 32'h0000_0000;
		rd_ok = 1'b1;
		case (s_axi_araddr[7:0])
			`ABR_OFF_CTRL: rd_mux[`ABR_CTRL_W-1:0] = ctrl_ff;
			`ABR_OFF_TERM: rd_mux[7:0] = term_ff;
			`ABR_OFF_CMD: rd_mux[1:0] = mode_ff;
			`ABR_OFF_STAT: begin
				rd_mux[`ABR_ST_AVAIL] = scan_avail;
				rd_mux[`ABR_ST_BUSY] = busy;
				rd_mux[`ABR_ST_FULL] = full;
			end
			`ABR_OFF_QRY: rd_mux = {{(16-CW){1'b0}}, q_blks_ff, {(16-CW){1'b0}}, q_scans_ff};
			`ABR_OFF_LVL: rd_mux = {{(16-CW){1'b0}}, blk_cnt_ff, {(16-CW){1'b0}}, scan_cnt_ff};
			`ABR_OFF_ISTAT: rd_mux[`ABR_IRQ_W-1:0] = istat_ff;
			`ABR_OFF_IMASK: rd_mux[`ABR_IRQ_W-1:0] = imask_ff;
			default: rd_ok = 1'b0;
		endcase
	end

	// Reads have no side effects, so a late rready costs nothing
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `ABR_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_ok ? `ABR_RESP_OKAY : `ABR_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule // abr_readout

`default_nettype wire

// ===== testbench/abr_readout_chk_asserts.sv
// Purpose: Port-level assertions for the buffer readout block.
// Assumes: Bound into abr_readout; one clock, synchronous active-low reset.
// Notes: Sees ports only, so mode-dependent token order is left to the bench.
`timescale 1ns/1ps
`default_nettype none

module abr_readout_chk #(
	parameter BURST_N = 256
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// Streams and status
	input wire logic acq_valid,
	input wire logic acq_ready,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic [31:0] out_data,
	input wire logic [1:0] out_tag,
	input wire logic scan_avail,
	input wire logic irq
);
	// ----
	// Properties
	// ----
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Leaving reset nothing is offered and capture stays closed until enabled
	AST_RST_IDLE: assert property (!$past(aresetn) |-> !out_valid && !s_axi_bvalid && !scan_avail && !irq && !acq_ready)
		else $error("outputs not idle after reset");
	AST_OUT_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_tag))
		else $error("queued token changed before it was taken");
	AST_SEP_DATA: assert property (out_valid && out_tag == 2'h1 |-> out_data == 32'h0000_0000)
		else $error("separator token carries data");
	AST_TERM_DATA: assert property (out_valid && out_tag[1] |-> out_data[31:4] == 28'h000_0000)
		else $error("terminator code wider than four bits");
	// A separator is always followed by a reading
	AST_SEP_NEXT: assert property (out_valid && out_ready && out_tag == 2'h1 |=> ##[0:4] (out_valid && out_tag == 2'h0))
		else $error("separator not followed by a reading");
	AST_AVAIL_RISE: assert property ($rose(scan_avail) |-> $past(acq_valid) && $past(acq_ready))
		else $error("scan available without a stored reading");
	// Both halves are latched first, so the response stands from the second edge on
	AST_B_AFTER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write response late");
	AST_R_AFTER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_REFUSE: assert property (s_axi_bvalid || s_axi_rvalid |-> !(s_axi_bvalid && s_axi_awready) && !(s_axi_rvalid && s_axi_arready))
		else $error("request taken while a response is pending");
	// Interrupt can only drop through a register write
	AST_IRQ_FALL: assert property ($fell(irq) |-> s_axi_bvalid)
		else $error("interrupt dropped without a write");
endmodule // abr_readout_chk

bind abr_readout abr_readout_chk #(.BURST_N(BURST_N)) u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .acq_valid,
	.acq_ready, .out_valid, .out_ready, .out_data, .out_tag, .scan_avail, .irq);
`default_nettype wire

// ===== testbench/abr_host_model.sv
// Purpose: Host side of the output queue; takes tokens and logs them.
// Assumes: Shares aclk with the readout block.
// Notes: With slow set, out_ready toggles each cycle to stall the block.
`timescale 1ns/1ps
`default_nettype none

module abr_host_model (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Output queue
	input wire logic out_valid,
	output logic out_ready,
	input wire logic [31:0] out_data,
	input wire logic [1:0] out_tag,
	// Pacing
	input wire logic slow
);
	// Token log, tag above data; the bench empties it before each request
	logic [33:0] got_q[$];

	// Drain everything offered, stalling on alternate cycles when slow
	always @(posedge aclk) begin
		if (!aresetn) begin
			out_ready <= 1'b0;
		end else begin
			if (out_valid && out_ready) begin
				got_q.push_back({out_tag, out_data});
			end
			out_ready <= slow ? !out_ready : 1'b1;
		end
	end
endmodule // abr_host_model
`default_nettype wire

// ===== testbench/tb_top.sv
// Purpose: Self-checking bench for the buffer readout block.
// Assumes: AXI4-Lite master tasks; the host model drains the output queue.
// Notes: Burst unit shortened to 4 readings to keep the run brief.
`timescale 1ns/1ps
`include "abr_defs.vh"
`default_nettype none

module tb_top;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, acq_valid, acq_ready, acq_scan_end;
	logic acq_block_end, out_valid, out_ready, scan_avail, irq, slow;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, acq_data, out_data;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, out_tag;
	logic [33:0] exp_q[$];
	int checks, bad_count;

	abr_readout #(.BURST_N(4)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .acq_valid,
		.acq_ready, .acq_data, .acq_scan_end, .acq_block_end, .out_valid, .out_ready, .out_data, .out_tag,
		.scan_avail, .irq);
	abr_host_model u_host (.aclk, .aresetn, .out_valid, .out_ready, .out_data, .out_tag, .slow);

	// ----
	// Tasks
	// ----
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	// Handshakes are judged at the falling edge, so they never race the design
	task automatic wr(input [7:0] a, input [31:0] d, output [1:0] r);
		logic ta, tw, tb;
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) break;
		end
		s_axi_bready <= 1'b0;
		if (n == 100) bad_count++;
	endtask

	task automatic rd(input [7:0] a, output [31:0] d, output [1:0] r);
		logic ta, tr;
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) break;
		end
		s_axi_rready <= 1'b0;
		if (n == 100) bad_count++;
	endtask

	task automatic rchk(input [7:0] a, input [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e);
	endtask

	// One reading into the buffer, waiting out back-pressure
	task automatic acq(input [31:0] d, input se, input be);
		logic hs;
		int n;
		@(posedge aclk);
		acq_valid <= 1'b1;
		acq_data <= d;
		acq_scan_end <= se;
		acq_block_end <= be;
		for (n = 0; n < 100; n++) begin
			@(negedge aclk);
			hs = acq_ready;
			@(posedge aclk);
			if (hs) break;
		end
		acq_valid <= 1'b0;
	endtask

	task automatic ex(input [1:0] t, input [31:0] d);
		exp_q.push_back({t, d});
	endtask

	// Clear events, issue a request, wait for the queue to drain, check event bit
	task automatic cmd(input [1:0] t, input [2:0] ev);
		logic [31:0] v;
		logic [1:0] r;
		int n;
		wr(`ABR_OFF_ISTAT, 32'h0000_0007, r);
		u_host.got_q.delete();
		wr(`ABR_OFF_CMD, {30'h0, t}, r);
		for (n = 0; n < 200; n++) begin
			rd(`ABR_OFF_STAT, v, r);
			if (v[`ABR_ST_BUSY] === 1'b0) break;
		end
		rd(`ABR_OFF_ISTAT, v, r);
		chk(v[2:0] & ev, ev);
	endtask

	task automatic toks();
		int i;
		chk(u_host.got_q.size(), exp_q.size());
		for (i = 0; i < exp_q.size() && i < u_host.got_q.size(); i++) chk(u_host.got_q[i], exp_q[i]);
		exp_q.delete();
	endtask

	task automatic results();
		$display("Checks %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ----
	// Clock, watchdog, sequence
	// ----
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// Whole sequence needs a few hundred cycles; 30000 means a hang
	initial begin
		#(100 * 30000);
		bad_count++;
		results();
	end

	initial begin
		logic [31:0] v;
		logic [1:0] r;
		int i;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, slow} = 7'h00;
		{acq_valid, acq_scan_end, acq_block_end, s_axi_awaddr, s_axi_araddr} = 19'h0_0000;
		{s_axi_wdata, acq_data} = 64'h0000_0000_0000_0000;
		s_axi_wstrb = 4'hf;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		// Every register starts at zero; an unmapped place is refused
		for (i = 0; i < 8; i++) begin
			rd(8'(i * 4), v, r);
			chk(v, 32'h0000_0000);
		end
		rd(8'h20, v, r);
		chk(r, `ABR_RESP_SLVERR);
		wr(8'h20, 32'h0000_0001, r);
		chk(r, `ABR_RESP_SLVERR);
		// Capture closed: readings are held off and nothing is buffered
		acq_valid <= 1'b1;
		repeat (3) @(negedge aclk);
		chk({acq_ready, scan_avail}, 2'b00);
		@(posedge aclk);
		acq_valid <= 1'b0;
		cmd(`ABR_TYPE_ONE, 3'h2);
		// ASCII with separators; scan term 1, block term 2
		wr(`ABR_OFF_CTRL, 32'h0000_0009, r);
		wr(`ABR_OFF_TERM, 32'h0000_0021, r);
		wr(`ABR_OFF_IMASK, 32'h0000_0001, r);
		acq(32'h0000_0011, 1'b0, 1'b0);
		acq(32'h0000_0012, 1'b1, 1'b0);
		acq(32'h0000_0021, 1'b1, 1'b1);
		acq(32'h0000_0031, 1'b1, 1'b0);
		@(negedge aclk);
		chk({scan_avail, irq}, 2'b11);
		rchk(`ABR_OFF_STAT, 32'h0000_0001);
		wr(`ABR_OFF_ISTAT, 32'h0000_0001, r);
		@(negedge aclk);
		chk(irq, 1'b0);
		cmd(`ABR_TYPE_QUERY, 3'h4);
		rchk(`ABR_OFF_QRY, 32'h0001_0003);
		rchk(`ABR_OFF_LVL, 32'h0001_0003);
		// Oldest scan only, with the host stalling
		slow <= 1'b1;
		ex(`ABR_TAG_READ, 32'h0000_0011);
		ex(`ABR_TAG_SEP, 32'h0000_0000);
		ex(`ABR_TAG_READ, 32'h0000_0012);
		ex(`ABR_TAG_SCAN, 32'h0000_0001);
		cmd(`ABR_TYPE_ONE, 3'h4);
		toks();
		slow <= 1'b0;
		ex(`ABR_TAG_READ, 32'h0000_0021);
		ex(`ABR_TAG_BLK, 32'h0000_0002);
		cmd(`ABR_TYPE_BLOCK, 3'h4);
		toks();
		cmd(`ABR_TYPE_BLOCK, 3'h2);
		toks();
		// Binary: readings only, then the buffer is empty
		wr(`ABR_OFF_CTRL, 32'h0000_000d, r);
		ex(`ABR_TAG_READ, 32'h0000_0031);
		cmd(`ABR_TYPE_ALL, 3'h4);
		toks();
		@(negedge aclk);
		chk(scan_avail, 1'b0);
		cmd(`ABR_TYPE_ONE, 3'h2);
		// Burst: four readings form one scan, no separators
		wr(`ABR_OFF_CTRL, 32'h0000_0003, r);
		for (i = 0; i < 4; i++) acq(32'h0000_0040 + i, 1'b0, 1'b0);
		@(negedge aclk);
		chk(scan_avail, 1'b1);
		for (i = 0; i < 4; i++) ex(`ABR_TAG_READ, 32'h0000_0040 + i);
		ex(`ABR_TAG_SCAN, 32'h0000_0001);
		cmd(`ABR_TYPE_ALL, 3'h4);
		toks();
		results();
	end
endmodule // tb_top
`default_nettype wire
